// File: design/mcu_instruction_execute.v
// instruction execute block with apb access to its state
`timescale 1ns/10ps
`default_nettype none
`include "mcu_exec_map.vh"

module mcu_instruction_execute (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // port pins seen by read-modify-write
  input  wire [7:0]  portPins,
  // prescaler pulses to the timer and watchdog logic, and the busy flag
  output reg         timerPrescClr,
  output reg         watchdogPrescClr,
  output wire        execBusy
);

  // architectural state
  reg [7:0]  workingQ;
  reg [7:0]  statusQ;
  reg [12:0] pcQ;
  reg [7:0]  pcHighQ;
  reg [7:0]  watchdogQ;
  reg [7:0]  fileMem [0:127];
  reg [12:0] stackMem [0:`STACK_DEPTH-1];
  reg [2:0]  spQ;
  reg [13:0] instrQ;
  reg        startQ;
  reg        nopCycleQ;
  reg [6:0]  faddrQ;
  reg        prescTimerQ;
  reg [31:0] rdMux;
  reg [7:0]  pinsMeta;
  reg [7:0]  pinsSync;

  // decode
  wire [6:0] fAddr  = instrQ[6:0];
  wire       dSel   = instrQ[7];
  wire [13:0] byteOp = instrQ & `OP_BYTE_MASK;
  wire isCall   = (instrQ & `OP_CALL_MASK) == `OP_CALL;
  wire isClearWatchdog = instrQ == `OP_CLEAR_WATCHDOG;
  wire isClearWorking  = (instrQ & `OP_CLEAR_MASK) == `OP_CLEAR_WORKING;
  wire isClearFile     = (instrQ & `OP_CLEAR_MASK) == `OP_CLEAR_FILE;
  wire isComplement    = byteOp == `OP_COMPLEMENT_FILE;
  wire isDecrement     = byteOp == `OP_DECREMENT_FILE;
  wire isDecSkip       = byteOp == `OP_DECREMENT_SKIP;
  wire isMove          = byteOp == `OP_MOVE_FILE;

  // operand fetch: the port reads pins, not the latch
  wire [7:0] fVal = (fAddr == `ADDR_PORT_A) ? pinsSync :
                    fileMem[fAddr];
  reg  [7:0] result;
  reg        writeF;
  reg        writeW;
  reg        zeroUpd;
  reg        skip;
  wire       resZero = (result == 8'h00);

  // result and destination selection
  always @* begin
    result  = 8'h00;
    writeF  = 1'b0;
    writeW  = 1'b0;
    zeroUpd = 1'b0;
    skip    = 1'b0;
    if (isClearFile) begin
      writeF  = 1'b1;
      zeroUpd = 1'b1;
    end else if (isClearWorking) begin
      writeW  = 1'b1;
      zeroUpd = 1'b1;
    end else if (isComplement) begin
      result  = ~fVal;
      writeF  = dSel;
      writeW  = ~dSel;
      zeroUpd = 1'b1;
    end else if (isDecrement || isDecSkip) begin
      result  = fVal - 8'h01;
      writeF  = dSel;
      writeW  = ~dSel;
      zeroUpd = isDecrement;
      skip    = isDecSkip && (fVal == 8'h01);
    end else if (isMove) begin
      result  = fVal;
      writeF  = dSel;
      writeW  = ~dSel;
      zeroUpd = 1'b1;
    end
  end

  // the second cycle blocks new starts so the bus sees the stall
  assign execBusy = nopCycleQ;
  assign pready   = 1'b1;
  assign pslverr  = 1'b0;

  wire wrEn = psel && penable && pwrite;
  // read data is captured in the setup cycle so it stands in the access
  wire rdSetup = psel && !penable && !pwrite;
  wire exec = startQ;

  // pin synchroniser, two stages before any use
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinsMeta <= 8'h00;
      pinsSync <= 8'h00;
    end else begin
      pinsMeta <= portPins;
      pinsSync <= pinsMeta;
    end
  end

  // file memory has no reset; it is plain ram
  always @(posedge sys_clk) begin
    if (exec && writeF)
      fileMem[fAddr] <= result;
    else if (wrEn && paddr == `REG_FDATA)
      fileMem[faddrQ] <= pwdata[7:0];
  end

  // stack push happens in the same edge that loads the new pc
  always @(posedge sys_clk) begin
    if (exec && isCall)
      stackMem[spQ] <= pcQ + 13'h0001;
  end

  // core state
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      workingQ     <= 8'h00;
      statusQ      <= `RST_STATUS;
      pcQ          <= 13'h0000;
      pcHighQ      <= 8'h00;
      watchdogQ    <= 8'h00;
      spQ          <= 3'h0;
      instrQ       <= 14'h0000;
      startQ       <= 1'b0;
      nopCycleQ    <= 1'b0;
      faddrQ       <= 7'h00;
      prescTimerQ  <= 1'b0;
      timerPrescClr    <= 1'b0;
      watchdogPrescClr <= 1'b0;
    end else begin
      startQ       <= 1'b0;
      timerPrescClr    <= 1'b0;
      watchdogPrescClr <= 1'b0;
      nopCycleQ    <= 1'b0;
      if (!exec && !nopCycleQ)
        watchdogQ <= watchdogQ + 8'h01;
      // software access
      if (wrEn) begin
        case (paddr)
          `REG_CTRL:    prescTimerQ <= pwdata[`CTRL_PRESC_TIMER];
          `REG_INSTR: begin
            instrQ <= pwdata[13:0];
            startQ <= !nopCycleQ && !startQ;
          end
          `REG_WORKING: workingQ <= pwdata[7:0];
          `REG_STATUS:  statusQ  <= pwdata[7:0];
          `REG_PCNT:    pcQ      <= pwdata[12:0];
          `REG_PC_HIGH: pcHighQ  <= pwdata[7:0];
          `REG_FADDR:   faddrQ   <= pwdata[6:0];
          default: ;
        endcase
      end
      if (exec) begin
        if (writeW)
          workingQ <= result;
        if (zeroUpd)
          statusQ[`ST_ZERO] <= resZero;
        if (writeF && fAddr == `ADDR_TIMER_COUNT && prescTimerQ)
          timerPrescClr <= 1'b1;
        if (writeF && fAddr == `ADDR_PC_HIGH)
          pcHighQ <= result;
        if (isClearWatchdog) begin
          watchdogQ        <= 8'h00;
          watchdogPrescClr <= 1'b1;
          statusQ[`ST_TIME_OUT]   <= 1'b1;
          statusQ[`ST_POWER_DOWN] <= 1'b1;
        end
        if (isCall) begin
          pcQ <= {pcHighQ[4:3], instrQ[10:0]};
          spQ <= spQ + 3'h1;
          nopCycleQ <= 1'b1;
        end else if (skip) begin
          pcQ <= pcQ + 13'h0002;
          nopCycleQ <= 1'b1;
        end else begin
          pcQ <= pcQ + 13'h0001;
        end
      end
    end
  end

  // read mux; unmapped offsets read as zero
  always @* begin
    case (paddr)
      `REG_CTRL:     rdMux = {31'h0, prescTimerQ};
      `REG_INSTR:    rdMux = {17'h0, execBusy, instrQ};
      `REG_WORKING:  rdMux = {24'h0, workingQ};
      `REG_STATUS:   rdMux = {24'h0, statusQ};
      `REG_PCNT:     rdMux = {19'h0, pcQ};
      `REG_PC_HIGH:  rdMux = {24'h0, pcHighQ};
      `REG_STACKTOP: rdMux = {19'h0, stackMem[spQ - 3'h1]};
      `REG_FADDR:    rdMux = {25'h0, faddrQ};
      `REG_FDATA:    rdMux = {24'h0, fileMem[faddrQ]};
      `REG_WATCHDOG: rdMux = {24'h0, watchdogQ};
      `REG_PINS:     rdMux = {24'h0, pinsSync};
      default:       rdMux = 32'h0000_0000;
    endcase
  end

  // read data flop: loaded in setup, zero outside a read access
  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (rdSetup)
      prdata <= rdMux;
    else
      prdata <= 32'h0000_0000;
  end

endmodule // mcu_instruction_execute
`default_nettype wire

// File: include/mcu_exec_map.vh
// constants for the instruction execute block
`ifndef MCU_EXEC_MAP_VH
`define MCU_EXEC_MAP_VH
// apb register byte offsets
`define REG_CTRL        12'h000
`define REG_INSTR       12'h004
`define REG_WORKING     12'h008
`define REG_STATUS      12'h00C
`define REG_PCNT        12'h010
`define REG_PC_HIGH     12'h014
`define REG_STACKTOP    12'h018
`define REG_FADDR       12'h01C
`define REG_FDATA       12'h020
`define REG_WATCHDOG    12'h024
`define REG_PINS        12'h028
// status bit positions
`define ST_ZERO         2
`define ST_POWER_DOWN   3
`define ST_TIME_OUT     4
// ctrl bit positions
`define CTRL_PRESC_TIMER 0
// file addresses
`define ADDR_TIMER_COUNT 7'h01
`define ADDR_PORT_A     7'h05
`define ADDR_PC_HIGH    7'h0A
// instruction opcodes (14-bit)
`define OP_CALL_MASK    14'h3800
`define OP_CALL         14'h2000
`define OP_CLEAR_WATCHDOG 14'h0064
`define OP_CLEAR_MASK   14'h3F80
`define OP_CLEAR_WORKING 14'h0100
`define OP_CLEAR_FILE   14'h0180
`define OP_BYTE_MASK    14'h3F00
`define OP_COMPLEMENT_FILE 14'h0900
`define OP_DECREMENT_FILE 14'h0300
`define OP_DECREMENT_SKIP 14'h0B00
`define OP_MOVE_FILE    14'h0800
// reset values and stack depth
`define RST_STATUS      8'h18
`define STACK_DEPTH     8
`endif

// File: tb/mcu_exec_properties.sv
// timing checks on the execute block ports
`timescale 1ns/10ps
`default_nettype none
`include "mcu_exec_map.vh"
module mcu_exec_properties (
  // clock, reset and bus
  input wire logic        sys_clk, rst, psel, penable, pwrite, pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // pins and pulses
  input wire logic [7:0]  portPins,
  input wire logic        pslverr, timerPrescClr, watchdogPrescClr, execBusy
);
  // an instruction word taken at the access edge
  wire        ins = psel && penable && pwrite && paddr == `REG_INSTR;
  wire [13:0] op  = pwdata[13:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_call; ins && (op & `OP_CALL_MASK) == `OP_CALL; endsequence
  sequence s_dog; ins && op == `OP_CLEAR_WATCHDOG; endsequence
  sequence s_clear_w;
    ins && (op & `OP_CLEAR_MASK) == `OP_CLEAR_WORKING;
  endsequence
  sequence s_dec;
    ins && (op & `OP_BYTE_MASK) == `OP_DECREMENT_FILE;
  endsequence
  property p_dog_clr; s_dog |-> ##[1:3] watchdogPrescClr; endproperty
  property p_dog_one; watchdogPrescClr |=> !watchdogPrescClr; endproperty
  property p_dog_call; s_call |=> !watchdogPrescClr [*4]; endproperty
  property p_call_busy; s_call |-> ##[1:4] execBusy; endproperty
  property p_busy_one; execBusy |=> !execBusy; endproperty
  property p_tmr_one; timerPrescClr |=> !timerPrescClr; endproperty
  property p_clear_quiet;
    s_clear_w |=> (!timerPrescClr && !watchdogPrescClr && !execBusy) [*4];
  endproperty
  property p_dec_busy; s_dec |=> !execBusy [*4]; endproperty
  a_dog_clr: assert property (p_dog_clr) else $error("no dog clear");
  a_dog_one: assert property (p_dog_one) else $error("dog pulse");
  a_dog_call: assert property (p_dog_call) else $error("dog by call");
  a_call_busy: assert property (p_call_busy) else $error("call 1 cycle");
  a_busy_one: assert property (p_busy_one) else $error("busy long");
  a_tmr_one: assert property (p_tmr_one) else $error("tmr pulse");
  a_clear_quiet: assert property (p_clear_quiet) else $error("noisy");
  a_dec_busy: assert property (p_dec_busy) else $error("dec busy");
endmodule // mcu_exec_properties
`default_nettype wire

// File: tb/tb_mcu_instruction_execute.sv
// self-checking bench for the execute block
`timescale 1ns/10ps
`default_nettype none
`include "mcu_exec_map.vh"
module tb_mcu_instruction_execute;
  logic        sys_clk = 1'b0, rst, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [7:0]  portPins, r = 8'h08, v, res;
  wire  [31:0] prdata;
  wire         pready, pslverr, timerPrescClr, watchdogPrescClr, execBusy;
  int          n_errors, n_checks, cyc, nTmr, nDog, n, i;
  logic [63:0] q[$];
  mcu_instruction_execute i_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .portPins(portPins), .timerPrescClr(timerPrescClr),
    .watchdogPrescClr(watchdogPrescClr), .execBusy(execBusy));
  always #25 sys_clk = ~sys_clk;
  function logic [7:0] nx(input logic [7:0] s);
    nx = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task stop_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one apb transfer; an idle edge after it keeps drivers single per step
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  // the read's expectation is noted first, the monitor compares it
  task rd(input logic [11:0] a, input logic [31:0] e, m);
    q.push_back({m, e & m});
    xfer(1'b0, a, 32'h00000000);
  endtask
  // spacing beyond the longest two-cycle instruction
  task ex(input logic [13:0] op);
    xfer(1'b1, `REG_INSTR, {18'h00000, op});
    repeat (4) @(posedge sys_clk);
  endtask
  // result monitor, pulse counter and hang guard
  always @(posedge sys_clk) begin
    logic [63:0] e;
    cyc++;
    if (timerPrescClr === 1'b1) nTmr++;
    if (watchdogPrescClr === 1'b1) nDog++;
    if (psel && penable && !pwrite && pready) begin
      e = q.pop_front();
      n_checks++;
      if (pslverr !== 1'b0) begin
        n_errors++;
        $display("BAD pslverr exp 0 got %b", pslverr);
      end
      if ((prdata & e[63:32]) !== e[31:0]) begin
        n_errors++;
        $display("BAD reg %h exp %h got %h", paddr, e[31:0],
                 prdata & e[63:32]);
      end
    end
    if (cyc == 20000) begin
      n_errors++;
      stop_test;
    end
  end
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, portPins} = 55'h0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(`REG_STATUS, 32'h18, 32'h18);
    rd(12'h3FC, 32'h0, 32'hFFFFFFFF);
    wr(`REG_WORKING, 32'h55);
    ex(`OP_CLEAR_WORKING);
    rd(`REG_WORKING, 32'h0, 32'hFF);
    rd(`REG_STATUS, 32'h4, 32'h4);
    r = nx(r);
    wr(`REG_FADDR, 32'h20);
    wr(`REG_FDATA, {24'h0, r | 8'h01});
    ex(`OP_CLEAR_FILE | 14'h0020);
    rd(`REG_FDATA, 32'h0, 32'hFF);
    rd(`REG_STATUS, 32'h4, 32'h4);
    // complement then decrement, each destination, zero and nonzero
    for (i = 0; i < 4; i++) begin
      r = nx(r);
      v = i == 0 ? 8'hFF : i == 2 ? 8'h01 : r;
      res = i < 2 ? ~v : v - 8'h01;
      wr(`REG_FDATA, {24'h0, v});
      ex((i < 2 ? `OP_COMPLEMENT_FILE : `OP_DECREMENT_FILE) |
         (i[0] ? 14'h00A0 : 14'h0020));
      rd(i[0] ? `REG_FDATA : `REG_WORKING, {24'h0, res}, 32'hFF);
      rd(`REG_STATUS, {29'h0, res == 8'h00, 2'h0}, 32'h4);
    end
    // zero flag is left set so a stray flag update shows up
    for (i = 0; i < 2; i++) begin
      v = i ? 8'h01 : 8'h03;
      ex(`OP_CLEAR_WORKING);
      wr(`REG_PCNT, 32'h100);
      wr(`REG_FDATA, {24'h0, v});
      ex(`OP_DECREMENT_SKIP | 14'h00A0);
      rd(`REG_PCNT, i ? 32'h102 : 32'h101, 32'h1FFF);
      rd(`REG_FDATA, {24'h0, v - 8'h01}, 32'hFF);
      rd(`REG_STATUS, 32'h4, 32'h4);
    end
    wr(`REG_PC_HIGH, 32'h08);
    wr(`REG_PCNT, 32'h0123);
    ex(`OP_CALL | 14'h07FF);
    rd(`REG_PCNT, 32'h0FFF, 32'h1FFF);
    rd(`REG_STACKTOP, 32'h0124, 32'h1FFF);
    wr(`REG_STATUS, 32'h0);
    n = nDog;
    ex(`OP_CLEAR_WATCHDOG);
    rd(`REG_WATCHDOG, 32'h0, 32'hFFFFFFF0);
    rd(`REG_STATUS, 32'h18, 32'h18);
    n_checks++;
    if (nDog - n !== 1) begin
      n_errors++;
      $display("BAD watchdogPrescClr exp 1 got %0d", nDog - n);
    end
    r = nx(r);
    portPins <= r;
    wr(`REG_FADDR, 32'h05);
    wr(`REG_FDATA, {24'h0, ~r});
    ex(`OP_MOVE_FILE | 14'h0085);
    rd(`REG_FDATA, {24'h0, r}, 32'hFF);
    // timer clear only while the prescaler belongs to timer zero
    for (i = 0; i < 2; i++) begin
      wr(`REG_CTRL, i);
      n = nTmr;
      ex(`OP_CLEAR_FILE | 14'h0001);
      n_checks++;
      if (nTmr - n !== i) begin
        n_errors++;
        $display("BAD timerPrescClr exp %0d got %0d", i, nTmr - n);
      end
    end
    stop_test;
  end
endmodule // tb_mcu_instruction_execute
bind mcu_instruction_execute mcu_exec_properties i_chk (.sys_clk(sys_clk),
  .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .portPins(portPins), .pslverr(pslverr), .timerPrescClr(timerPrescClr),
  .watchdogPrescClr(watchdogPrescClr), .execBusy(execBusy));
`default_nettype wire
